// File: osc_cfg_regs.sv
// Configuration and mailbox registers of the optical proximity sensor
// Operation
// - Interval high and low bytes form one 16-bit wake interval.
// - Wake-ups are spaced by interval times 31.25 us.
// - Each wake-up runs every measurement enabled in the channel list.
// - Early sequencer revision maps low byte at 0x0A, high at 0x08.
// - Emitter pair register: emitter 2 in bits 7:4, emitter 1 in 3:0.
// - Drive code 0000 is off, 0001 minimum, 1111 maximum current.
// - Third emitter drive sits in bits 3:0; bits 7:4 reserved.
// - Parameter inbox carries a byte to the sequencer; resets to zero.
// - A command register write submits the byte as a command.
// - Only a command register write leaves standby.
// - Without pending error, response bits 3:0 count finished commands.
// - An error code is kept, commands ignored until reset or no-op.
`default_nettype none

module osc_cfg_regs #(
  parameter int TICK_CYCLES = osc_pkg::WAKE_TICK_CYCLES,
  parameter int CHAN_W = 8,
  parameter bit EARLY_SEQ_REV = 1'b0,
  parameter logic [7:0] NOP_CODE = 8'h00,
  parameter logic [7:0] RESET_CODE = 8'h01
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [CHAN_W-1:0] channel_list_i,
  input wire logic seq_done_i,
  input wire logic seq_err_i,
  input wire logic [7:0] seq_err_code_i,
  input wire logic seq_sleep_i,
  output logic standby_o,
  output logic key_ok_o,
  output logic cmd_valid_o,
  output logic [7:0] cmd_code_o,
  output logic [7:0] param_o,
  output logic [osc_pkg::WAKE_W-1:0] wake_interval_o,
  output logic meas_start_o,
  output logic [CHAN_W-1:0] meas_chan_o,
  output logic [3:0] emitter1_drive_o,
  output logic [3:0] emitter2_drive_o,
  output logic [3:0] emitter3_drive_o,
  output logic [osc_pkg::EMITTER_N-1:0] emitter_on_o
);

  generate
    if (CHAN_W < 1) begin : g_bad_chan
      $error("osc_cfg_regs: CHAN_W must be at least 1");
    end
    if (NOP_CODE == RESET_CODE) begin : g_bad_codes
      $error("osc_cfg_regs: no-op and reset codes must differ");
    end
  endgenerate

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] unlock_key;
    logic [7:0] wake_interval_low;
    logic [7:0] wake_interval_high;
    logic [7:0] emitter_drive_pair;
    logic [3:0] emitter_drive_third;
    logic [7:0] param_inbox;
    logic [7:0] command_inbox;
    logic [7:0] response;
    logic standby;
    logic key_ok;
    logic cmd_valid;
    logic [7:0] rdata;
    logic meas_start;
    logic [CHAN_W-1:0] meas_chan;
    logic [osc_pkg::EMITTER_N-1:0] emitter_on;
    logic interval_restart;
    osc_pkg::osc_cmd_state_e cmd_state;
  } osc_regs_s;

  osc_regs_s st;
  osc_regs_s next_st;

  logic wake;
  logic [osc_pkg::WAKE_W-1:0] wake_interval;
  logic [7:0] addr_low;
  logic [7:0] addr_high;
  logic hit_low;
  logic hit_high;
  logic clears_error;
  logic error_pending;
  logic [osc_pkg::EMITTER_N*osc_pkg::EMITTER_W-1:0] drive_codes;
  logic [osc_pkg::EMITTER_N-1:0] next_emitter_on;

  // ---------------------------------------------------------------
  // Interval byte mapping and combined value
  // ---------------------------------------------------------------
  assign addr_low = EARLY_SEQ_REV ? osc_pkg::ADDR_EARLY_WAKE_LOW
                                  : osc_pkg::ADDR_WAKE_LOW;
  assign addr_high = EARLY_SEQ_REV ? osc_pkg::ADDR_EARLY_WAKE_HIGH
                                   : osc_pkg::ADDR_WAKE_HIGH;
  assign hit_low = reg_addr_i == addr_low;
  assign hit_high = reg_addr_i == addr_high;
  assign wake_interval = {st.wake_interval_high,
                          st.wake_interval_low};

  assign error_pending = st.response[osc_pkg::RESP_ERR_BIT];
  assign clears_error = reg_wdata_i == NOP_CODE || reg_wdata_i == RESET_CODE;

  // ---------------------------------------------------------------
  // Emitter activity: a zero code means no current
  // ---------------------------------------------------------------
  assign drive_codes = {next_st.emitter_drive_third,
                        next_st.emitter_drive_pair};

  genvar gi;
  generate
    for (gi = 0; gi < osc_pkg::EMITTER_N; gi++) begin : g_emitter
      assign next_emitter_on[gi] =
        drive_codes[gi*osc_pkg::EMITTER_W +: osc_pkg::EMITTER_W]
        != osc_pkg::EMITTER_OFF;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Wake timer
  // ---------------------------------------------------------------
  osc_wake_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_wake_timer (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .interval_i(wake_interval),
    .restart_i(st.interval_restart),
    .wake_o(wake)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.cmd_valid = 1'b0;
    next_st.meas_start = 1'b0;
    next_st.interval_restart = 1'b0;

    // Register writes
    if (reg_wr_i) begin
      if (hit_low) begin
        next_st.wake_interval_low = reg_wdata_i;
        next_st.interval_restart = 1'b1;
      end
      if (hit_high) begin
        next_st.wake_interval_high = reg_wdata_i;
        next_st.interval_restart = 1'b1;
      end
      unique case (reg_addr_i)
        osc_pkg::ADDR_UNLOCK_KEY: begin
          next_st.unlock_key = reg_wdata_i;
        end
        osc_pkg::ADDR_DRIVE_PAIR: begin
          next_st.emitter_drive_pair = reg_wdata_i;
        end
        osc_pkg::ADDR_DRIVE_THIRD: begin
          next_st.emitter_drive_third =
            reg_wdata_i[osc_pkg::EMITTER_W-1:0];
        end
        osc_pkg::ADDR_PARAM_INBOX: begin
          next_st.param_inbox = reg_wdata_i;
        end
        osc_pkg::ADDR_COMMAND_INBOX: begin
          next_st.command_inbox = reg_wdata_i;
          next_st.standby = 1'b0;
          if (!error_pending || clears_error) begin
            next_st.cmd_valid = 1'b1;
            next_st.cmd_state = osc_pkg::OSC_BUSY;
            if (clears_error) begin
              next_st.response = osc_pkg::RST_BYTE;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Command completion from the sequencer
    unique case (st.cmd_state)
      osc_pkg::OSC_IDLE: begin
      end
      osc_pkg::OSC_BUSY: begin
        if (seq_done_i && !st.cmd_valid) begin
          next_st.cmd_state = osc_pkg::OSC_IDLE;
          if (seq_err_i) begin
            next_st.response = seq_err_code_i;
            next_st.response[osc_pkg::RESP_ERR_BIT] = 1'b1;
          end else if (!error_pending) begin
            next_st.response[osc_pkg::RESP_CNT_W-1:0] =
              st.response[osc_pkg::RESP_CNT_W-1:0]
              + osc_pkg::RESP_CNT_STEP;
          end
        end
      end
    endcase

    // Return to standby once the sequencer is idle, unless woken now
    if (seq_sleep_i && !(reg_wr_i
        && reg_addr_i == osc_pkg::ADDR_COMMAND_INBOX)) begin
      next_st.standby = 1'b1;
    end

    // Autonomous wake-up, independent of any pending error
    if (wake && channel_list_i != '0) begin
      next_st.meas_start = 1'b1;
      next_st.meas_chan = channel_list_i;
    end

    // Register reads
    if (reg_rd_i) begin
      next_st.rdata = osc_pkg::RST_BYTE;
      if (hit_low) begin
        next_st.rdata = st.wake_interval_low;
      end else if (hit_high) begin
        next_st.rdata = st.wake_interval_high;
      end else begin
        unique case (reg_addr_i)
          osc_pkg::ADDR_UNLOCK_KEY: begin
            next_st.rdata = st.unlock_key;
          end
          osc_pkg::ADDR_DRIVE_PAIR: begin
            next_st.rdata = st.emitter_drive_pair;
          end
          osc_pkg::ADDR_DRIVE_THIRD: begin
            next_st.rdata = {osc_pkg::RST_NIBBLE,
                             st.emitter_drive_third};
          end
          osc_pkg::ADDR_PARAM_INBOX: begin
            next_st.rdata = st.param_inbox;
          end
          osc_pkg::ADDR_COMMAND_INBOX: begin
            next_st.rdata = st.command_inbox;
          end
          osc_pkg::ADDR_RESPONSE: begin
            next_st.rdata = st.response;
          end
          default: begin
          end
        endcase
      end
    end

    next_st.key_ok =
      next_st.unlock_key == osc_pkg::UNLOCK_KEY_VALUE;
    next_st.emitter_on = next_emitter_on;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st.unlock_key <= osc_pkg::RST_BYTE;
      st.wake_interval_low <= osc_pkg::RST_BYTE;
      st.wake_interval_high <= osc_pkg::RST_BYTE;
      st.emitter_drive_pair <= osc_pkg::RST_BYTE;
      st.emitter_drive_third <= osc_pkg::RST_NIBBLE;
      st.param_inbox <= osc_pkg::RST_BYTE;
      st.command_inbox <= osc_pkg::RST_BYTE;
      st.response <= osc_pkg::RST_BYTE;
      st.standby <= 1'b1;
      st.key_ok <= 1'b0;
      st.cmd_valid <= 1'b0;
      st.rdata <= osc_pkg::RST_BYTE;
      st.meas_start <= 1'b0;
      st.meas_chan <= '0;
      st.emitter_on <= '0;
      st.interval_restart <= 1'b0;
      st.cmd_state <= osc_pkg::OSC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o = st.rdata;
  assign standby_o = st.standby;
  assign key_ok_o = st.key_ok;
  assign cmd_valid_o = st.cmd_valid;
  assign cmd_code_o = st.command_inbox;
  assign param_o = st.param_inbox;
  assign wake_interval_o = wake_interval;
  assign meas_start_o = st.meas_start;
  assign meas_chan_o = st.meas_chan;
  assign emitter1_drive_o = st.emitter_drive_pair[osc_pkg::EMITTER_W-1:0];
  assign emitter2_drive_o =
    st.emitter_drive_pair[osc_pkg::PAIR_HI_LSB +: osc_pkg::EMITTER_W];
  assign emitter3_drive_o = st.emitter_drive_third;
  assign emitter_on_o = st.emitter_on;

endmodule

`default_nettype wire

// File: osc_pkg.sv
// Shared constants of the optical sensor configuration register bank
`default_nettype none

package osc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h07;
  localparam logic [7:0] ADDR_WAKE_LOW = 8'h08;
  localparam logic [7:0] ADDR_WAKE_HIGH = 8'h09;
  localparam logic [7:0] ADDR_EARLY_WAKE_LOW = 8'h0a;
  localparam logic [7:0] ADDR_EARLY_WAKE_HIGH = 8'h08;
  localparam logic [7:0] ADDR_DRIVE_PAIR = 8'h0f;
  localparam logic [7:0] ADDR_DRIVE_THIRD = 8'h10;
  localparam logic [7:0] ADDR_PARAM_INBOX = 8'h17;
  localparam logic [7:0] ADDR_COMMAND_INBOX = 8'h18;
  localparam logic [7:0] ADDR_RESPONSE = 8'h20;

  // ---------------------------------------------------------------
  // Reset values and key
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [7:0] UNLOCK_KEY_VALUE = 8'h17;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int EMITTER_W = 4;
  localparam int EMITTER_N = 3;
  localparam int PAIR_HI_LSB = 4;
  localparam int RESP_ERR_BIT = 7;
  localparam int RESP_CNT_W = 4;
  localparam int WAKE_W = 16;
  localparam logic [3:0] EMITTER_OFF = 4'h0;
  localparam logic [3:0] RESP_CNT_STEP = 4'h1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real WAKE_TICK_US = 31.25;
  localparam int WAKE_TICK_CYCLES =
    int'(WAKE_TICK_US * 1000.0 / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // Command flow states
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    OSC_IDLE = 1'b0,
    OSC_BUSY = 1'b1
  } osc_cmd_state_e;

endpackage

`default_nettype wire

// File: osc_wake_timer.sv
// Autonomous wake-up interval timer
`default_nettype none

module osc_wake_timer #(
  parameter int TICK_CYCLES = osc_pkg::WAKE_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [osc_pkg::WAKE_W-1:0] interval_i,
  input wire logic restart_i,
  output logic wake_o
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  generate
    if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("osc_wake_timer: TICK_CYCLES must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [TICK_W-1:0] tick;
    logic [osc_pkg::WAKE_W-1:0] units;
    logic wake;
  } osc_timer_s;

  osc_timer_s st;
  osc_timer_s next_st;

  // ---------------------------------------------------------------
  // Interval count: ticks of one unit, units up to the interval
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.wake = 1'b0;
    if (restart_i || interval_i == '0) begin
      next_st.tick = '0;
      next_st.units = '0;
    end else if (st.tick == TICK_LAST) begin
      next_st.tick = '0;
      if (st.units == interval_i - osc_pkg::WAKE_W'(1)) begin
        next_st.units = '0;
        next_st.wake = 1'b1;
      end else begin
        next_st.units = st.units + osc_pkg::WAKE_W'(1);
      end
    end else begin
      next_st.tick = st.tick + TICK_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wake_o = st.wake;

endmodule

`default_nettype wire

// File: osc_cfg_regs_props.sv
// Concurrent checks on the configuration register bank ports
`default_nettype none

module osc_cfg_regs_props #(
  parameter bit EARLY_SEQ_REV = 1'b0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic standby_o,
  input wire logic key_ok_o,
  input wire logic cmd_valid_o,
  input wire logic [7:0] cmd_code_o,
  input wire logic [7:0] param_o,
  input wire logic [osc_pkg::WAKE_W-1:0] wake_interval_o,
  input wire logic meas_start_o,
  input wire logic [3:0] emitter1_drive_o,
  input wire logic [3:0] emitter2_drive_o,
  input wire logic [3:0] emitter3_drive_o,
  input wire logic [osc_pkg::EMITTER_N-1:0] emitter_on_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_cmd_src;
    cmd_valid_o |-> $past(reg_wr_i)
      && $past(reg_addr_i) == osc_pkg::ADDR_COMMAND_INBOX;
  endproperty
  a_cmd_src: assert property (p_cmd_src)
    else $error("command pulse without a command write");

  property p_cmd_code;
    reg_wr_i && reg_addr_i == osc_pkg::ADDR_COMMAND_INBOX
      |=> cmd_code_o == $past(reg_wdata_i);
  endproperty
  a_cmd_code: assert property (p_cmd_code)
    else $error("command byte not stored");

  property p_wake;
    $fell(standby_o) |-> $past(reg_wr_i)
      && $past(reg_addr_i) == osc_pkg::ADDR_COMMAND_INBOX;
  endproperty
  a_wake: assert property (p_wake)
    else $error("standby left without a command write");

  property p_high;
    reg_wr_i && reg_addr_i == (EARLY_SEQ_REV ? osc_pkg::ADDR_EARLY_WAKE_HIGH
                                             : osc_pkg::ADDR_WAKE_HIGH)
      |=> wake_interval_o[15:8] == $past(reg_wdata_i);
  endproperty
  a_high: assert property (p_high)
    else $error("interval high byte wrong");

  property p_pair;
    reg_wr_i && reg_addr_i == osc_pkg::ADDR_DRIVE_PAIR
      |=> {emitter2_drive_o, emitter1_drive_o} == $past(reg_wdata_i);
  endproperty
  a_pair: assert property (p_pair)
    else $error("emitter pair fields wrong");

  property p_third;
    reg_wr_i && reg_addr_i == osc_pkg::ADDR_DRIVE_THIRD
      |=> emitter3_drive_o == $past(reg_wdata_i[3:0]);
  endproperty
  a_third: assert property (p_third)
    else $error("third emitter field wrong");

  property p_on;
    emitter_on_o == {emitter3_drive_o != 4'h0, emitter2_drive_o != 4'h0,
      emitter1_drive_o != 4'h0};
  endproperty
  a_on: assert property (p_on)
    else $error("emitter enable disagrees with drive code");

  property p_param;
    reg_wr_i && reg_addr_i == osc_pkg::ADDR_PARAM_INBOX
      |=> param_o == $past(reg_wdata_i);
  endproperty
  a_param: assert property (p_param)
    else $error("parameter inbox not stored");

  property p_key;
    reg_wr_i && reg_addr_i == osc_pkg::ADDR_UNLOCK_KEY
      |=> key_ok_o == ($past(reg_wdata_i) == osc_pkg::UNLOCK_KEY_VALUE);
  endproperty
  a_key: assert property (p_key)
    else $error("key flag wrong");

  property p_off;
    meas_start_o |-> wake_interval_o != 16'h0000;
  endproperty
  a_off: assert property (p_off)
    else $error("wake-up with zero interval");

  property p_unmapped;
    reg_rd_i && reg_addr_i == 8'h11 |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("reserved address read nonzero");
endmodule

bind osc_cfg_regs osc_cfg_regs_props #(
  .EARLY_SEQ_REV(EARLY_SEQ_REV)
) u_props (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .standby_o(standby_o),
  .key_ok_o(key_ok_o),
  .cmd_valid_o(cmd_valid_o),
  .cmd_code_o(cmd_code_o),
  .param_o(param_o),
  .wake_interval_o(wake_interval_o),
  .meas_start_o(meas_start_o),
  .emitter1_drive_o(emitter1_drive_o),
  .emitter2_drive_o(emitter2_drive_o),
  .emitter3_drive_o(emitter3_drive_o),
  .emitter_on_o(emitter_on_o)
);

`default_nettype wire

// File: osc_seq_model.sv
// Behavioural sequencer that answers submitted commands
`default_nettype none

module osc_seq_model #(
  parameter logic [7:0] FAIL_CMD = 8'h3c
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [3:0] delay_i,
  output logic seq_done_o,
  output logic seq_err_o,
  output logic [7:0] seq_err_code_o,
  output logic seq_sleep_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic fail;

  // Answers after delay_i cycles, then drops back to sleep
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 4'h0;
      fail <= 1'b0;
      seq_done_o <= 1'b0;
      seq_sleep_o <= 1'b0;
    end else begin
      seq_done_o <= 1'b0;
      seq_sleep_o <= seq_done_o;
      if (cmd_valid_i) begin
        cnt <= delay_i;
        fail <= (cmd_code_i == FAIL_CMD);
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        seq_done_o <= (cnt == 4'h1);
      end
    end
  end
  assign seq_err_o = seq_done_o & fail;
  // Code is only meaningful with done; otherwise a junk pattern
  assign seq_err_code_o = seq_done_o ? 8'h08 : 8'hf7;
endmodule

`default_nettype wire

// File: testbench.sv
// Self-checking bench of the configuration register bank
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] channel_list_i = 8'h25;
  logic [3:0] delay_i = 4'h6;
  logic seq_done_i, seq_err_i, seq_sleep_i, standby_o, key_ok_o;
  logic cmd_valid_o, meas_start_o;
  logic [7:0] seq_err_code_i, reg_rdata_o, cmd_code_o, param_o, meas_chan_o;
  logic [15:0] wake_interval_o;
  logic [3:0] emitter1_drive_o, emitter2_drive_o, emitter3_drive_o;
  logic [2:0] emitter_on_o;
  logic [15:0] e_interval;
  logic [3:0] c [3] = '{4'h0, 4'h1, 4'hf};
  int n_fail = 0;
  int samples_checked = 0;
  int gap;

  osc_cfg_regs #(.TICK_CYCLES(TICK)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .channel_list_i(channel_list_i), .seq_done_i(seq_done_i),
    .seq_err_i(seq_err_i), .seq_err_code_i(seq_err_code_i),
    .seq_sleep_i(seq_sleep_i), .standby_o(standby_o), .key_ok_o(key_ok_o),
    .cmd_valid_o(cmd_valid_o), .cmd_code_o(cmd_code_o), .param_o(param_o),
    .wake_interval_o(wake_interval_o), .meas_start_o(meas_start_o),
    .meas_chan_o(meas_chan_o), .emitter1_drive_o(emitter1_drive_o),
    .emitter2_drive_o(emitter2_drive_o), .emitter3_drive_o(emitter3_drive_o),
    .emitter_on_o(emitter_on_o));

  // Early sequencer revision on the same bus: interval high byte at 0x08, low byte at 0x0a
  osc_cfg_regs #(.TICK_CYCLES(TICK), .EARLY_SEQ_REV(1'b1)) u_early (
    .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(), .channel_list_i(channel_list_i),
    .seq_done_i(seq_done_i), .seq_err_i(seq_err_i),
    .seq_err_code_i(seq_err_code_i), .seq_sleep_i(seq_sleep_i),
    .standby_o(), .key_ok_o(), .cmd_valid_o(), .cmd_code_o(), .param_o(),
    .wake_interval_o(e_interval), .meas_start_o(), .meas_chan_o(),
    .emitter1_drive_o(), .emitter2_drive_o(), .emitter3_drive_o(),
    .emitter_on_o());

  osc_seq_model u_seq (.clk_i(clk_i), .nrst_i(nrst_i),
    .cmd_valid_i(cmd_valid_o), .cmd_code_i(cmd_code_o), .delay_i(delay_i),
    .seq_done_o(seq_done_i), .seq_err_o(seq_err_i),
    .seq_err_code_o(seq_err_code_i), .seq_sleep_o(seq_sleep_i));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // Access and check tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge clk_i);
    #1 reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1 reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge clk_i);
    #1 reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask

  task automatic rc(input string what, input logic [7:0] a,
                    input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask

  // Host-style polling of the response register
  task automatic poll(input logic [7:0] exp);
    logic [7:0] d;
    for (int i = 0; i < 40; i++) begin
      rd(osc_pkg::ADDR_RESPONSE, d);
      if (d === exp) break;
    end
    check("response", d, exp);
    if (d !== exp) begin
      end_sim();
    end
  endtask

  task automatic wait_meas(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (meas_start_o !== 1'b1 && n < 1100);
    if (n >= 1100) begin
      n_fail++;
      end_sim();
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    check("standby", standby_o, 1'b1);
    rc("param", osc_pkg::ADDR_PARAM_INBOX, 8'h00);
    rc("key", osc_pkg::ADDR_UNLOCK_KEY, 8'h00);
    rc("pair", osc_pkg::ADDR_DRIVE_PAIR, 8'h00);
    wr(osc_pkg::ADDR_UNLOCK_KEY, osc_pkg::UNLOCK_KEY_VALUE);
    check("key_ok", key_ok_o, 1'b1);
    wr(osc_pkg::ADDR_PARAM_INBOX, 8'ha5);
    check("param_o", param_o, 8'ha5);
    rc("unmapped", 8'h11, 8'h00);
    check("standby", standby_o, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(osc_pkg::ADDR_DRIVE_PAIR, {c[i], c[2-i]});
      wr(osc_pkg::ADDR_DRIVE_THIRD, {4'hf, c[i]});
      check("emitter1", emitter1_drive_o, c[2-i]);
      check("emitter2", emitter2_drive_o, c[i]);
      check("emitter3", emitter3_drive_o, c[i]);
      check("on", emitter_on_o,
            {c[i] != 0, c[i] != 0, c[2-i] != 0});
      rc("third", osc_pkg::ADDR_DRIVE_THIRD, {4'h0, c[i]});
    end
    wr(osc_pkg::ADDR_WAKE_LOW, 8'h02);
    wr(osc_pkg::ADDR_WAKE_HIGH, 8'h01);
    check("interval", wake_interval_o, 16'h0102);
    wr(osc_pkg::ADDR_EARLY_WAKE_LOW, 8'h03);
    check("early", e_interval, 16'h0203);
    check("interval", wake_interval_o, 16'h0102);
    wait_meas(gap);
    check("chan", meas_chan_o, 8'h25);
    channel_list_i = 8'h5a;
    wait_meas(gap);
    check("period", gap, 16'd258 * TICK);
    check("chan", meas_chan_o, 8'h5a);
    wr(osc_pkg::ADDR_COMMAND_INBOX, 8'h05);
    check("cmd_valid", cmd_valid_o, 1'b1);
    check("cmd_code", cmd_code_o, 8'h05);
    check("standby", standby_o, 1'b0);
    poll(8'h01);
    delay_i = 4'h1;
    wr(osc_pkg::ADDR_COMMAND_INBOX, 8'h06);
    poll(8'h02);
    wr(osc_pkg::ADDR_COMMAND_INBOX, 8'h3c);
    poll(8'h88);
    wr(osc_pkg::ADDR_COMMAND_INBOX, 8'h05);
    check("ignored", cmd_valid_o, 1'b0);
    wait_meas(gap);
    wait_meas(gap);
    check("period_err", gap, 16'd258 * TICK);
    poll(8'h88);
    delay_i = 4'hf;
    wr(osc_pkg::ADDR_COMMAND_INBOX, 8'h00);
    poll(8'h00);
    poll(8'h01);
    end_sim();
  end
endmodule

`default_nettype wire
